// ---- dcp_params.svh ----
`ifndef DCP_PARAMS_SVH
`define DCP_PARAMS_SVH

// ============================================================
// Panel geometry
`define DCP_COLUMNS 1920
`define DCP_ACTIVE_LINES 1080
`define DCP_ACTIVE_PAIRS 960
`define DCP_FRAME_LINES_MIN 1092
`define DCP_FRAME_LINES_MAX 1793
`define DCP_LINE_CLKS_MIN 1004
`define DCP_LINE_CLKS_MAX 1100

// ============================================================
// Frame detection
// A low run longer than the longest line can only be vertical blanking
`define DCP_LONG_BLANK_CLKS 11'h44d

// ============================================================
// Lane bit positions, 7 bits per lane per link clock
`define DCP_LANE_BITS 7
`define DCP_DE_BIT 6
`define DCP_LSB6_HI 5
`define DCP_COL_BITS 10
`define DCP_ROW_BITS 11

// ============================================================
// Reset values and buffer sizes
`define DCP_FIFO_AW 2
`define DCP_SKID_DEPTH 2
`define DCP_COL_RESET 10'h000
`define DCP_ROW_RESET 11'h000
`define DCP_RUN_RESET 11'h000

`endif

// ---- dcp_pkg.sv ----
package dcp_pkg;
`include "dcp_params.svh"

	typedef logic [7:0] dcp_comp_type;

	// Subpixel order red, green, blue; bit 7 most significant
	typedef struct packed {
		dcp_comp_type red;
		dcp_comp_type green;
		dcp_comp_type blue;
	} dcp_pixel_type;

	typedef struct packed {
		dcp_pixel_type oddPix;
		dcp_pixel_type evenPix;
		logic [`DCP_COL_BITS-1:0] pairCol;
		logic [`DCP_ROW_BITS-1:0] row;
		logic frameStart;
	} dcp_word_type;

	typedef enum logic [2:0] {
		ST_HUNT = 3'h1,
		ST_BLANK = 3'h2,
		ST_ACTIVE = 3'h4
	} dcp_state_type;

endpackage

// ---- dcp_stream_if.sv ----
interface dcp_stream_if;
	import dcp_pkg::*;
	dcp_word_type data;
	logic valid;
	logic ready;
	modport source (output data, output valid, input ready);
	modport sink (input data, input valid, output ready);
endinterface

// ---- dcp_skid_buf.sv ----
module dcp_skid_buf import dcp_pkg::*; #(
	parameter int WIDTH = $bits(dcp_word_type),
	parameter int DEPTH = `DCP_SKID_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	dcp_stream_if.sink up,
	dcp_stream_if.source dn
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// ============================================================
	// Storage
	logic [WIDTH-1:0] slotReg [DEPTH];
	logic [PW-1:0] wrIdx_reg;
	logic [PW-1:0] rdIdx_reg;
	logic [PW:0] count_reg;
	wire push = ce && up.valid && up.ready;
	wire pop = ce && dn.valid && dn.ready;
	wire [PW-1:0] wrIdxNext = (wrIdx_reg == PW'(DEPTH - 1)) ? '0 : wrIdx_reg + 1'b1;
	wire [PW-1:0] rdIdxNext = (rdIdx_reg == PW'(DEPTH - 1)) ? '0 : rdIdx_reg + 1'b1;

	// Ready from the count only, so the source never sees a loop
	assign up.ready = (count_reg != (PW+1)'(DEPTH));
	assign dn.valid = (count_reg != '0);
	assign dn.data = dcp_word_type'(slotReg[rdIdx_reg]);

	// Data slots, no reset needed on payload
	always_ff @(posedge clk) begin
		if (push) begin
			slotReg[wrIdx_reg] <= WIDTH'(up.data);
		end
	end

	// Pointers and fill count
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wrIdx_reg <= '0;
			rdIdx_reg <= '0;
			count_reg <= '0;
		end else begin
			if (push) begin
				wrIdx_reg <= wrIdxNext;
			end
			if (pop) begin
				rdIdx_reg <= rdIdxNext;
			end
			count_reg <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule

// ---- dcp_panel_rx.sv ----
// Behaviour
// - Panel takes frame and line timing from data enable only, no syncs.
// - Each colour component is eight bits, bit 7 most significant.
// - Odd pixels ride the odd channel, even pixels the even one.
// - Data enable rides the third odd lane alongside odd pixel bits.
// - Panel maps pixels onto 1920 columns by 1080 lines, red-green-blue.
module dcp_panel_rx import dcp_pkg::*; #(
	parameter int FIFO_AW = `DCP_FIFO_AW,
	parameter int SKID_DEPTH = `DCP_SKID_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic oddChannelClock,
	input wire logic [`DCP_LANE_BITS-1:0] oddLaneA,
	input wire logic [`DCP_LANE_BITS-1:0] oddLaneB,
	input wire logic [`DCP_LANE_BITS-1:0] oddLaneC,
	input wire logic [`DCP_LANE_BITS-1:0] oddLaneD,
	input wire logic [`DCP_LANE_BITS-1:0] evenLaneA,
	input wire logic [`DCP_LANE_BITS-1:0] evenLaneB,
	input wire logic [`DCP_LANE_BITS-1:0] evenLaneC,
	input wire logic [`DCP_LANE_BITS-1:0] evenLaneD,
	output dcp_pixel_type oddPixel,
	output dcp_pixel_type evenPixel,
	output logic [`DCP_COL_BITS-1:0] pairColumn,
	output logic [`DCP_ROW_BITS-1:0] lineIndex,
	output logic frameStart,
	output logic pixelValid,
	input wire logic pixelReady,
	output logic frameLocked,
	output logic overflowSeen
);
	localparam int DEPTH = 1 << FIFO_AW;

	// ============================================================
	// Lane unpacking, same map for both channels
	function automatic dcp_pixel_type unpackPixel(
		input logic [`DCP_LANE_BITS-1:0] la,
		input logic [`DCP_LANE_BITS-1:0] lb,
		input logic [`DCP_LANE_BITS-1:0] lc,
		input logic [`DCP_LANE_BITS-1:0] ld
	);
		dcp_pixel_type px;
		px.red = {ld[1:0], la[`DCP_LSB6_HI:0]};
		px.green = {ld[3:2], lb[4:0], la[6]};
		px.blue = {ld[5:4], lc[3:0], lb[6:5]};
		return px;
	endfunction

	function automatic logic [FIFO_AW:0] toGray(input logic [FIFO_AW:0] b);
		return b ^ (b >> 1);
	endfunction

	// ============================================================
	// Link-domain reset and clock enable
	// Reset asserts at once but releases on the link clock, so the
	// link state never leaves reset on a partial edge
	logic [1:0] linkRstPipe_reg;
	logic [1:0] ceLinkPipe_reg;
	wire linkRst = linkRstPipe_reg[1];
	wire ceLink = ceLinkPipe_reg[1];

	always_ff @(posedge oddChannelClock or posedge rst) begin
		if (rst) begin
			linkRstPipe_reg <= 2'h3;
		end else begin
			linkRstPipe_reg <= {linkRstPipe_reg[0], 1'b0};
		end
	end

	// Enable is a level from the system domain
	always_ff @(posedge oddChannelClock or posedge linkRst) begin
		if (linkRst) begin
			ceLinkPipe_reg <= 2'h0;
		end else begin
			ceLinkPipe_reg <= {ceLinkPipe_reg[0], ce};
		end
	end

	// ============================================================
	// Lane capture on the odd clock
	// Even lanes are taken on the odd clock too, which holds only
	// because both channel clocks share one timing
	logic [`DCP_LANE_BITS-1:0] oddA_reg, oddB_reg, oddC_reg, oddD_reg;
	logic [`DCP_LANE_BITS-1:0] evenA_reg, evenB_reg, evenC_reg, evenD_reg;

	always_ff @(posedge oddChannelClock or posedge linkRst) begin
		if (linkRst) begin
			{oddA_reg, oddB_reg, oddC_reg, oddD_reg} <= '0;
			{evenA_reg, evenB_reg, evenC_reg, evenD_reg} <= '0;
		end else if (ceLink) begin
			{oddA_reg, oddB_reg, oddC_reg, oddD_reg} <= {oddLaneA, oddLaneB, oddLaneC, oddLaneD};
			{evenA_reg, evenB_reg, evenC_reg, evenD_reg} <=
				{evenLaneA, evenLaneB, evenLaneC, evenLaneD};
		end
	end

	// ============================================================
	// Timing recovery from data enable alone
	dcp_state_type state_reg, state_next;
	logic [`DCP_COL_BITS-1:0] col_reg, col_next;
	logic [`DCP_ROW_BITS-1:0] row_reg, row_next;
	logic [10:0] lowRun_reg;
	logic sofPend_reg, sofPend_next;

	wire deNow = oddC_reg[`DCP_DE_BIT];
	// Blanking past the longest line can only be vertical
	wire longBlank = (lowRun_reg >= `DCP_LONG_BLANK_CLKS);
	wire [10:0] lowRunNext = deNow ? `DCP_RUN_RESET :
		(longBlank ? lowRun_reg : lowRun_reg + 11'h001);
	wire lineOpen = (state_reg == ST_ACTIVE);
	wire frameOpen = (state_reg == ST_BLANK) && sofPend_reg;
	wire [`DCP_COL_BITS-1:0] wordCol = lineOpen ? col_reg : `DCP_COL_RESET;
	wire [`DCP_ROW_BITS-1:0] wordRow = frameOpen ? `DCP_ROW_RESET : row_reg;
	// Pixels outside the grid are dropped, never wrapped
	wire inGrid = (wordCol < `DCP_COL_BITS'(`DCP_ACTIVE_PAIRS)) &&
		(wordRow < `DCP_ROW_BITS'(`DCP_ACTIVE_LINES));
	wire wordFire = deNow && (state_reg != ST_HUNT) && inGrid;

	// Next-state decode
	always_comb begin
		state_next = state_reg;
		col_next = col_reg;
		row_next = row_reg;
		sofPend_next = sofPend_reg;
		case (state_reg)
			ST_HUNT: begin
				if (longBlank) begin
					state_next = ST_BLANK;
					sofPend_next = 1'b1;
				end
			end
			ST_BLANK: begin
				if (deNow) begin
					state_next = ST_ACTIVE;
					col_next = `DCP_COL_BITS'(1);
					sofPend_next = 1'b0;
					if (sofPend_reg) begin
						row_next = `DCP_ROW_RESET;
					end
				end else if (longBlank) begin
					sofPend_next = 1'b1;
				end
			end
			ST_ACTIVE: begin
				if (deNow) begin
					if (col_reg != '1) begin
						col_next = col_reg + 1'b1;
					end
				end else begin
					state_next = ST_BLANK;
					col_next = `DCP_COL_RESET;
					if (row_reg != '1) begin
						row_next = row_reg + 1'b1;
					end
				end
			end
			default: begin
				state_next = ST_HUNT;
				sofPend_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge oddChannelClock or posedge linkRst) begin
		if (linkRst) begin
			state_reg <= ST_HUNT;
			col_reg <= `DCP_COL_RESET;
			row_reg <= `DCP_ROW_RESET;
			lowRun_reg <= `DCP_RUN_RESET;
			sofPend_reg <= 1'b0;
		end else if (ceLink) begin
			state_reg <= state_next;
			col_reg <= col_next;
			row_reg <= row_next;
			lowRun_reg <= lowRunNext;
			sofPend_reg <= sofPend_next;
		end
	end

	// Lock held in one flop, so the crossing samples a clean level
	// rather than a decode of the state bits
	logic locked_reg;

	always_ff @(posedge oddChannelClock or posedge linkRst) begin
		if (linkRst) begin
			locked_reg <= 1'b0;
		end else if (ceLink) begin
			locked_reg <= (state_next != ST_HUNT);
		end
	end

	// ============================================================
	// Word assembly: odd channel carries odd pixels, even the even
	dcp_word_type linkWord;
	assign linkWord.oddPix = unpackPixel(oddA_reg, oddB_reg, oddC_reg, oddD_reg);
	assign linkWord.evenPix = unpackPixel(evenA_reg, evenB_reg, evenC_reg, evenD_reg);
	assign linkWord.pairCol = wordCol;
	assign linkWord.row = wordRow;
	assign linkWord.frameStart = frameOpen;

	// ============================================================
	// Crossing FIFO, gray pointers
	// The link cannot be stalled, so a full FIFO drops the word and
	// latches an overflow flag instead
	logic [$bits(dcp_word_type)-1:0] fifoMem [DEPTH];
	logic [FIFO_AW:0] wrBin_reg, wrGray_reg, rdBin_reg, rdGray_reg;
	logic [FIFO_AW:0] rdGrayS1_reg, rdGrayS2_reg, wrGrayS1_reg, wrGrayS2_reg;
	logic overflow_reg;
	wire fifoFull = (wrGray_reg ==
		{~rdGrayS2_reg[FIFO_AW:FIFO_AW-1], rdGrayS2_reg[FIFO_AW-2:0]});
	wire fifoWrite = ceLink && wordFire && !fifoFull;
	wire [FIFO_AW:0] wrBinNext = wrBin_reg + 1'b1;

	always_ff @(posedge oddChannelClock) begin
		if (fifoWrite) begin
			fifoMem[wrBin_reg[FIFO_AW-1:0]] <= linkWord;
		end
	end

	// Write pointer, read pointer sync, overflow catch
	always_ff @(posedge oddChannelClock or posedge linkRst) begin
		if (linkRst) begin
			wrBin_reg <= '0;
			wrGray_reg <= '0;
			rdGrayS1_reg <= '0;
			rdGrayS2_reg <= '0;
			overflow_reg <= 1'b0;
		end else if (ceLink) begin
			rdGrayS1_reg <= rdGray_reg;
			rdGrayS2_reg <= rdGrayS1_reg;
			if (fifoWrite) begin
				wrBin_reg <= wrBinNext;
				wrGray_reg <= toGray(wrBinNext);
			end
			if (wordFire && fifoFull) begin
				overflow_reg <= 1'b1;
			end
		end
	end

	// ============================================================
	// System-domain read side
	dcp_stream_if fifoOut ();
	dcp_stream_if bufOut ();
	wire fifoEmpty = (rdGray_reg == wrGrayS2_reg);
	wire fifoRead = ce && fifoOut.valid && fifoOut.ready;
	wire [FIFO_AW:0] rdBinNext = rdBin_reg + 1'b1;
	logic [1:0] lockedPipe_reg;
	logic [1:0] ovfPipe_reg;

	assign fifoOut.valid = !fifoEmpty;
	assign fifoOut.data = dcp_word_type'(fifoMem[rdBin_reg[FIFO_AW-1:0]]);

	// Read pointer, write pointer sync and status level syncs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdBin_reg <= '0;
			rdGray_reg <= '0;
			wrGrayS1_reg <= '0;
			wrGrayS2_reg <= '0;
			lockedPipe_reg <= 2'h0;
			ovfPipe_reg <= 2'h0;
		end else if (ce) begin
			wrGrayS1_reg <= wrGray_reg;
			wrGrayS2_reg <= wrGrayS1_reg;
			lockedPipe_reg <= {lockedPipe_reg[0], locked_reg};
			ovfPipe_reg <= {ovfPipe_reg[0], overflow_reg};
			if (fifoRead) begin
				rdBin_reg <= rdBinNext;
				rdGray_reg <= toGray(rdBinNext);
			end
		end
	end

	// ============================================================
	// Two-entry buffer absorbs receiver stalls
	dcp_skid_buf #(
		.WIDTH($bits(dcp_word_type)),
		.DEPTH(SKID_DEPTH)
	) u_skid (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.up(fifoOut),
		.dn(bufOut)
	);

	assign bufOut.ready = pixelReady;
	assign pixelValid = bufOut.valid;
	assign oddPixel = bufOut.data.oddPix;
	assign evenPixel = bufOut.data.evenPix;
	assign pairColumn = bufOut.data.pairCol;
	assign lineIndex = bufOut.data.row;
	assign frameStart = bufOut.data.frameStart;
	assign frameLocked = lockedPipe_reg[1];
	assign overflowSeen = ovfPipe_reg[1];
endmodule

// ---- dcp_panel_rx_monitor.sv ----
module dcp_panel_rx_monitor import dcp_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire dcp_pixel_type oddPixel,
	input wire dcp_pixel_type evenPixel,
	input wire logic [9:0] pairColumn,
	input wire logic [10:0] lineIndex,
	input wire logic frameStart,
	input wire logic pixelValid,
	input wire logic pixelReady,
	input wire logic frameLocked,
	input wire logic overflowSeen
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	// ============================================================
	// Last pair taken, so order can be judged without a model
	logic take;
	logic seen_reg;
	logic [9:0] lastCol_reg;
	logic [10:0] lastRow_reg;
	logic cont;
	assign take = pixelValid && pixelReady && ce;
	// Dropped words break the sequence, so order checks stop after overflow
	assign cont = pixelValid && seen_reg && !frameStart && !overflowSeen;

	// Capture on every accepted pair
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			seen_reg <= 1'b0;
			lastCol_reg <= 10'h000;
			lastRow_reg <= 11'h000;
		end else if (take) begin
			seen_reg <= 1'b1;
			lastCol_reg <= pairColumn;
			lastRow_reg <= lineIndex;
		end
	end

	// ============================================================
	// Output stream checks
	a_stall_holds_word: assert property (pixelValid && !take |=> pixelValid
		&& $stable(oddPixel) && $stable(evenPixel) && $stable(pairColumn) && $stable(lineIndex))
		else $error("pair changed while stalled");
	a_start_at_origin: assert property (pixelValid && frameStart |->
		pairColumn == 10'h000 && lineIndex == 11'h000) else $error("frame start not at origin");
	a_column_in_range: assert property (pixelValid |-> pairColumn < 10'h3c0)
		else $error("pair column out of range");
	a_row_in_range: assert property (pixelValid |-> lineIndex < 11'h438)
		else $error("line index out of range");
	a_column_steps: assert property (cont && lineIndex == lastRow_reg |->
		pairColumn == lastCol_reg + 10'h001) else $error("column skipped");
	a_row_steps: assert property (cont |-> lineIndex == lastRow_reg
		|| lineIndex == lastRow_reg + 11'h001) else $error("line skipped");
	a_line_begins_left: assert property (cont && lineIndex != lastRow_reg |->
		pairColumn == 10'h000) else $error("new line not at column zero");
	a_lock_is_sticky: assert property (frameLocked |=> frameLocked)
		else $error("lock lost");
	a_overflow_sticky: assert property (overflowSeen |=> overflowSeen)
		else $error("overflow flag cleared");
endmodule

// ---- dcp_src_model.sv ----
module dcp_src_model import dcp_pkg::*; (
	input wire logic deReq,
	input wire logic [10:0] rowReq,
	input wire logic [9:0] colReq,
	output logic oddChannelClock,
	output logic [6:0] oddLaneA,
	output logic [6:0] oddLaneB,
	output logic [6:0] oddLaneC,
	output logic [6:0] oddLaneD,
	output logic [6:0] evenLaneA,
	output logic [6:0] evenLaneB,
	output logic [6:0] evenLaneC,
	output logic [6:0] evenLaneD
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [27:0] oddW;
	logic [27:0] evenW;
	dcp_pixel_type junk = 24'h5a3c96;

	// Free running link clock, odd phase so edges never meet the system clock
	// Far below the pixel rate and without spread; nothing here counts time
	initial begin
		oddChannelClock = 1'b0;
		#3.3;
		forever #62.5 oddChannelClock = ~oddChannelClock;
	end

	// ============================================================
	// Lane packing, enable on the third odd lane
	function automatic logic [27:0] enc(input dcp_pixel_type p, input logic de);
		enc = {1'b0, p.blue[7:6], p.green[7:6], p.red[7:6], de, 2'b00, p.blue[5:2],
			p.blue[1:0], p.green[5:1], p.green[0], p.red[5:0]};
	endfunction

	function automatic dcp_pixel_type pat(input int r, input int c, input logic o);
		pat.red = 8'(c * 7 + r * 3 + o);
		pat.green = ~8'(c * 5);
		pat.blue = 8'(r) ^ (o ? 8'h96 : 8'h69);
	endfunction

	// Blanking lanes carry a pattern that moves every clock
	always @(negedge oddChannelClock) begin
		junk <= ~junk + 24'h000013;
	end

	// Pair asked for by the bench, odd pixel on the odd channel
	assign oddW = deReq ? enc(pat(rowReq, colReq, 1'b1), 1'b1) :
		enc(junk, 1'b0);
	assign evenW = deReq ? enc(pat(rowReq, colReq, 1'b0), 1'b1) :
		enc(~junk, 1'b0);

	// One clock for both channels keeps them in lockstep
	// Lanes always driven: the supply never drops, so no release window
	assign {oddLaneD, oddLaneC, oddLaneB, oddLaneA} = oddW;
	assign {evenLaneD, evenLaneC, evenLaneB, evenLaneA} = evenW;
endmodule

// ---- dcp_panel_rx_tb.sv ----
module dcp_panel_rx_tb import dcp_pkg::*; ();
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic pixelReady = 1'b0;
	logic oddChannelClock;
	logic deReq = 1'b0;
	logic [10:0] rowReq = 11'h000;
	logic [9:0] colReq = 10'h000;
	logic [6:0] oA, oB, oC, oD, eA, eB, eC, eD;
	dcp_pixel_type oddPixel;
	dcp_pixel_type evenPixel;
	logic [9:0] pairColumn;
	logic [10:0] lineIndex;
	logic frameStart, pixelValid, frameLocked, overflowSeen;
	int nMismatch = 0;
	int cmpCount = 0;

	always #5 clk = ~clk;

	dcp_src_model SRC (.deReq(deReq), .rowReq(rowReq), .colReq(colReq),
		.oddChannelClock(oddChannelClock), .oddLaneA(oA), .oddLaneB(oB),
		.oddLaneC(oC), .oddLaneD(oD), .evenLaneA(eA), .evenLaneB(eB), .evenLaneC(eC),
		.evenLaneD(eD));

	dcp_panel_rx DUT (.clk(clk), .rst(rst), .ce(ce),
		.oddChannelClock(oddChannelClock), .oddLaneA(oA), .oddLaneB(oB), .oddLaneC(oC),
		.oddLaneD(oD), .evenLaneA(eA), .evenLaneB(eB), .evenLaneC(eC), .evenLaneD(eD),
		.oddPixel(oddPixel), .evenPixel(evenPixel), .pairColumn(pairColumn),
		.lineIndex(lineIndex), .frameStart(frameStart), .pixelValid(pixelValid),
		.pixelReady(pixelReady), .frameLocked(frameLocked), .overflowSeen(overflowSeen));

	// ============================================================
	// Verdict and comparison
	task automatic endOfTest();
		if (nMismatch == 0 && cmpCount > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		cmpCount++;
		if (seen !== exp) begin
			nMismatch++;
			$display("[ERR] %0t %s", $time, what);
		end
	endtask

	function automatic dcp_pixel_type expPix(input int r, input int c, input logic o);
		expPix.red = 8'(c * 7 + r * 3 + o);
		expPix.green = ~8'(c * 5);
		expPix.blue = 8'(r) ^ (o ? 8'h96 : 8'h69);
	endfunction

	// Wait bounded for a pair, judge it, let the next edge take it
	task automatic getPair(input int r, input int c, input logic fs);
		int k;
		k = 0;
		while (pixelValid !== 1'b1 && k < 4000) begin
			@(negedge clk);
			k++;
		end
		check(k < 4000, 1'b1, "no pair arrived");
		if (k == 4000)
			endOfTest();
		check(oddPixel, expPix(r, c, 1'b1), "odd pixel");
		check(evenPixel, expPix(r, c, 1'b0), "even pixel");
		check({lineIndex, pairColumn, frameStart}, {11'(r), 10'(c), fs}, "position");
		@(negedge clk);
	endtask

	// Blanking: enable low for n link clocks
	task automatic blank(input int n);
		repeat (n) begin
			@(negedge oddChannelClock);
			deReq = 1'b0;
		end
	endtask

	// Active pairs of line r, one pair per link clock
	task automatic line(input int r, input int n);
		for (int c = 0; c < n; c++) begin
			@(negedge oddChannelClock);
			deReq = 1'b1;
			rowReq = 11'(r);
			colReq = 10'(c);
		end
	endtask

	task automatic rcvLine(input int r, input int n, input logic fs);
		for (int c = 0; c < n; c++)
			getPair(r, c, fs && c == 0);
	endtask

	// ============================================================
	// Scenarios
	task automatic tHunt(); // A blank one clock short must not lock
		line(0, 2);
		blank(1100);
		line(0, 2);
		blank(20);
		@(negedge clk);
		check({frameLocked, pixelValid}, 2'b00, "locked on short blank");
	endtask

	task automatic tFrame();
		pixelReady = 1'b1;
		blank(1101);
		// Frame cut to three lines to keep the run short; last line overruns
		fork
			begin
				line(0, 4);
				blank(20);
				line(1, 4);
				blank(20);
				line(2, 962);
				blank(20);
			end
			begin
				rcvLine(0, 4, 1'b1);
				rcvLine(1, 4, 1'b0);
				rcvLine(2, 960, 1'b0);
			end
		join
		check(frameLocked, 1'b1, "not locked");
		check(pixelValid, 1'b0, "pair past the grid");
	endtask

	task automatic tStall(); // Second frame held back, then clock enable low
		@(negedge clk);
		pixelReady = 1'b0;
		blank(1101);
		line(0, 5);
		blank(30);
		@(negedge clk);
		ce = 1'b0;
		repeat (3) @(negedge clk);
		pixelReady = 1'b1;
		repeat (3) @(negedge clk);
		check({pixelValid, pairColumn}, {1'b1, 10'h000}, "taken without enable");
		ce = 1'b1;
		rcvLine(0, 5, 1'b1);
		repeat (20) @(negedge clk);
		check(pixelValid, 1'b0, "extra pair");
	endtask

	task automatic tOverflow(); // Fill until refused, then drain to empty
		int n;
		pixelReady = 1'b0;
		line(1, 10);
		blank(20);
		@(negedge clk);
		check(overflowSeen, 1'b1, "no overflow");
		pixelReady = 1'b1;
		getPair(1, 0, 1'b0);
		n = 1;
		repeat (200) begin
			n += (pixelValid === 1'b1);
			@(negedge clk);
		end
		check(n >= 6 && n < 10, 1'b1, "buffer depth");
		check({pixelValid, overflowSeen}, 2'b01, "drain state");
	endtask

	// ============================================================
	// Main sequence; reset spans three link clocks
	initial begin
		repeat (40) @(negedge clk);
		rst = 1'b0;
		// Link reset and enable syncs need about four link clocks to settle
		repeat (60) @(negedge clk);
		tHunt();
		tFrame();
		tStall();
		tOverflow();
		endOfTest();
	end

	// Hang guard
	initial begin
		repeat (90000) @(posedge clk);
		nMismatch++;
		endOfTest();
	end
endmodule

bind dcp_panel_rx dcp_panel_rx_monitor MON (.clk(clk), .rst(rst), .ce(ce),
	.oddPixel(oddPixel), .evenPixel(evenPixel), .pairColumn(pairColumn),
	.lineIndex(lineIndex), .frameStart(frameStart), .pixelValid(pixelValid),
	.pixelReady(pixelReady), .frameLocked(frameLocked), .overflowSeen(overflowSeen));
